// ===== dv/sap_host_model.sv
// host and analog front end facing the converter pins
// assumes its tasks are called right after a rising edge of mclk_i
`timescale 1ns/100ps

module sap_host_model (
    input wire logic mclk_i,
    input wire logic [11:0] trial_i,
    input wire logic [11:0] vin_i,
    output logic cs_n_o,
    output logic rd_conv_o,
    output logic high_byte_select_o,
    output logic comp_o
);
    // comparator: held input at or above the trial word
    assign comp_o = (vin_i >= trial_i);

    // idle host: deselected, read/convert high
    initial begin
        cs_n_o = 1'b1;
        rd_conv_o = 1'b1;
        high_byte_select_o = 1'b0;
    end

    // select and byte mode, changed on an edge with no command
    task automatic sel(input logic sel_n, input logic hb);
        @(posedge mclk_i);
        cs_n_o <= sel_n;
        high_byte_select_o <= hb;
    endtask : sel

    // select first, then a falling edge of read/convert one cycle later
    task automatic fall(input logic sel_n, input logic hb);
        sel(sel_n, hb);
        @(posedge mclk_i);
        rd_conv_o <= 1'b0;
    endtask : fall

    // level of read/convert, caller keeps a low pulse 2 cycles or more
    task automatic set_rc(input logic v);
        rd_conv_o <= v;
    endtask : set_rc
endmodule : sap_host_model

// ===== dv/tb.sv
// self-checking bench of the converter control block
// assumes the host model above and a 100 MHz clock
`timescale 1ns/100ps

module tb;
    logic mclk_i, rst_i, cs_n, rd_conv, high_byte_select, busy_n, comp, read_i, write_i, waitreq, irq;
    logic [11:0] trial, vin;
    logic [3:0] address;
    logic [31:0] writedata, readdata, rv;
    sap_pkg::sap_word_t data, oe;
    int n_fail, tests_run, lows;
    logic [11:0] codes [3] = '{12'h000, 12'hFFF, 12'h5A3};

    sap_adc_ctrl u_dut (
        .mclk_i(mclk_i), .rst_i(rst_i), .cs_n_i(cs_n), .rd_conv_i(rd_conv),
        .high_byte_select_i(high_byte_select), .busy_n_o(busy_n), .data_o(data), .data_oe_o(oe),
        .comp_i(comp), .trial_o(trial), .address_i(address), .read_i(read_i),
        .write_i(write_i), .writedata_i(writedata), .byteenable_i(4'hF),
        .readdata_o(readdata), .waitrequest_o(waitreq), .irq_o(irq)
    );

    sap_host_model u_host (
        .mclk_i(mclk_i), .trial_i(trial), .vin_i(vin), .cs_n_o(cs_n),
        .rd_conv_o(rd_conv), .high_byte_select_o(high_byte_select), .comp_o(comp)
    );

    // clock
    initial begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end

    // compare and count
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : give_verdict

    // one avalon access, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
        int i;
        @(posedge mclk_i);
        address <= a;
        read_i <= !wr;
        write_i <= wr;
        writedata <= wd;
        i = 0;
        // wait for the answer; only the watchdog ends a hung access
        do begin
            @(posedge mclk_i);
            i++;
        end while (waitreq !== 1'b0);
        rv = readdata;
        read_i <= 1'b0;
        write_i <= 1'b0;
        check("bus wait edges", 32'(i), 32'h2);
    endtask : bus

    // one conversion; poke adds a second falling edge while busy
    task automatic convert(input logic [11:0] code, input int div, input bit poke);
        int n;
        vin <= code;
        u_host.fall(1'b0, 1'b0);
        lows = 0;
        for (n = 1; n < 400; n++) begin
            @(posedge mclk_i);
            if (busy_n === 1'b1 && n > 2) break;
            if (busy_n === 1'b0) lows++;
            if (n == 4 || n == 9) u_host.set_rc(1'b1);
            if (poke && n == 7) u_host.set_rc(1'b0);
            if (n == 6) check("oe busy", {20'h0, oe}, 32'h0);
        end
        check("busy low cycles", 32'(lows), 32'(12 * (div + 1) + 2));
        check("data at busy rise", {20'h0, data}, {20'h0, code});
        check("trial final", {20'h0, trial}, {20'h0, code});
        repeat (2) @(posedge mclk_i);
        check("word", {20'h0, data}, {20'h0, code});
        check("oe word", {20'h0, oe}, {20'h0, sap_pkg::OE_ALL});
    endtask : convert

    // no conversion may start: busy stays high
    task automatic no_start(input logic sel_n, input logic hb, input logic [31:0] st);
        lows = 0;
        u_host.fall(sel_n, hb);
        repeat (30) begin
            @(posedge mclk_i);
            if (busy_n !== 1'b1) lows++;
        end
        u_host.set_rc(1'b1);
        check("busy refused", 32'(lows), 32'h0);
        bus(1'b0, sap_pkg::OFS_STATUS, 32'h0);
        check("status refused", rv, st);
    endtask : no_start

    task automatic t_reset();
        check("busy reset", {31'h0, busy_n}, 32'h1);
        check("oe reset", {20'h0, oe}, 32'h0);
        check("irq reset", {31'h0, irq}, 32'h0);
        bus(1'b0, sap_pkg::OFS_CTRL, 32'h0);
        check("ctrl reset", rv, 32'h13);
        bus(1'b0, 4'h2, 32'h0);
        check("unmapped", rv, 32'h0);
        bus(1'b1, sap_pkg::OFS_MASK, 32'h1);
        bus(1'b0, sap_pkg::OFS_MASK, 32'h0);
        check("mask", rv, 32'h1);
        $display("test reset done");
    endtask : t_reset

    // default step length, byte modes, deselect and interrupt
    task automatic t_bytes();
        convert(12'hA5C, 8'h13, 1'b0);
        check("irq done", {31'h0, irq}, 32'h1);
        u_host.sel(1'b0, 1'b1);
        repeat (2) @(posedge mclk_i);
        check("high byte", {20'h0, data}, 32'h00A0A);
        u_host.sel(1'b1, 1'b0);
        repeat (2) @(posedge mclk_i);
        check("oe deselected", {20'h0, oe}, 32'h0);
        bus(1'b0, sap_pkg::OFS_STATUS, 32'h0);
        check("status done", rv, 32'h1);
        repeat (3) @(posedge mclk_i);
        check("irq cleared", {31'h0, irq}, 32'h0);
        bus(1'b0, sap_pkg::OFS_RESULT, 32'h0);
        check("result reg", rv, 32'h00A5C);
        $display("test bytes done");
    endtask : t_bytes

    // fastest steps, boundary codes, edge while busy ignored
    task automatic t_fast();
        bus(1'b1, sap_pkg::OFS_CTRL, 32'h0);
        foreach (codes[k]) begin
            convert(codes[k], 0, k == 1);
            bus(1'b0, sap_pkg::OFS_STATUS, 32'h0);
            check("status", rv, (k == 1) ? 32'h3 : 32'h1);
        end
        $display("test fast done");
    endtask : t_fast

    task automatic t_refuse();
        no_start(1'b0, 1'b1, 32'h4);
        no_start(1'b1, 1'b0, 32'h0);
        $display("test refuse done");
    endtask : t_refuse

    // watchdog
    initial begin
        #500000;
        n_fail++;
        give_verdict();
    end

    // main sequence
    initial begin
        n_fail = 0;
        tests_run = 0;
        rst_i = 1'b1;
        read_i = 1'b0;
        write_i = 1'b0;
        address = 4'h0;
        writedata = 32'h0;
        vin = 12'h000;
        repeat (16) @(posedge mclk_i);
        rst_i <= 1'b0;
        t_reset();
        t_bytes();
        t_fast();
        t_refuse();
        give_verdict();
    end
endmodule : tb

// ===== src/sap_adc_ctrl.sv
// control and output interface of a 12-bit sampling converter
// assumes pins are synchronous to mclk_i; tri-state resolved outside
`timescale 1ns/100ps

//Contract
// - top nibble always carries bits eleven to eight
// - middle nibble is bits 7..4, else low
// - low nibble is bits 3..0, else 11..8
// - select low gives full twelve bit word
// - start on falling edge, selected, low byte, idle
// - deselected means all data lines undriven
// - busy low for whole conversion
// - result valid at rising edge of busy
// - convert edges ignored while busy
// - busy rises only after result latched
module sap_adc_ctrl (
    input wire logic mclk_i,
    input wire logic rst_i,
    // converter pins
    input wire logic cs_n_i,
    input wire logic rd_conv_i,
    input wire logic high_byte_select_i,
    output logic busy_n_o,
    output sap_pkg::sap_word_t data_o,
    output sap_pkg::sap_word_t data_oe_o,
    // analog side
    input wire logic comp_i,
    output logic [11:0] trial_o,
    // avalon-mm slave
    input wire logic [3:0] address_i,
    input wire logic read_i,
    input wire logic write_i,
    input wire logic [31:0] writedata_i,
    input wire logic [3:0] byteenable_i,
    output logic [31:0] readdata_o,
    output logic waitrequest_o,
    output logic irq_o
);

    sap_pkg::sap_state_t state_q;
    sap_pkg::sap_state_t state_d;
    sap_pkg::sap_irq_t status_q;
    sap_pkg::sap_irq_t mask_q;
    sap_pkg::sap_irq_t events;
    sap_pkg::sap_irq_t clr_bits;
    sap_pkg::sap_word_t data_d;
    logic [7:0] step_div_q;
    logic [11:0] latch_q;
    logic [11:0] sar_result;
    logic [31:0] rd_mux;
    logic rc_q;
    logic rc_fall;
    logic start_cmd;
    logic sar_done;
    logic sar_run;
    logic bus_req;
    logic bus_done;
    logic oe_d;

    // falling edge of the convert line
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            rc_q <= 1'b1;
        end else begin
            rc_q <= rd_conv_i;
        end
    end

    // a one-cycle low is taken; the host keeps the longer pulse itself
    assign rc_fall = rc_q && !rd_conv_i;

    // start only when selected, low byte and not busy
    assign start_cmd = rc_fall && !cs_n_i && !high_byte_select_i
        && (state_q == sap_pkg::SAP_IDLE);

    // events for the interrupt status
    always_comb begin
        events = sap_pkg::IRQ_NONE;
        events.done = (state_q == sap_pkg::SAP_XFER);
        events.ignored = rc_fall && (state_q != sap_pkg::SAP_IDLE);
        events.inhibit = rc_fall && !cs_n_i && high_byte_select_i
            && (state_q == sap_pkg::SAP_IDLE);
    end

    sap_sar_engine u_sar (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .start_i(start_cmd),
        .step_div_i(step_div_q),
        .comp_i(comp_i),
        .trial_o(trial_o),
        .result_o(sar_result),
        .done_o(sar_done),
        .run_o(sar_run)
    );

    // sequence: idle, convert, transfer into the output latch
    always_comb begin
        state_d = state_q;
        case (state_q)
            sap_pkg::SAP_IDLE: begin
                if (start_cmd) begin
                    state_d = sap_pkg::SAP_CONV;
                end
            end
            sap_pkg::SAP_CONV: begin
                if (sar_done) begin
                    state_d = sap_pkg::SAP_XFER;
                end
            end
            sap_pkg::SAP_XFER: begin
                state_d = sap_pkg::SAP_IDLE;
            end
            default: begin
                state_d = sap_pkg::SAP_IDLE;
            end
        endcase
    end

    // state register, comes up idle
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            state_q <= sap_pkg::SAP_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // output latch loads as the result is handed over
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            latch_q <= sap_pkg::RES_RST;
        end else if (sar_done && state_q == sap_pkg::SAP_CONV) begin
            latch_q <= sar_result;
        end
    end

    // busy low from start until the transfer is over
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            busy_n_o <= 1'b1;
        end else begin
            busy_n_o <= (state_d == sap_pkg::SAP_IDLE);
        end
    end

    // pin formatting by high byte select
    always_comb begin
        data_d.top = latch_q[11:8];
        if (high_byte_select_i) begin
            data_d.mid = sap_pkg::NIB_LOW;
            data_d.low = latch_q[11:8];
        end else begin
            data_d = latch_q;
        end
    end

    // drive only when selected, idle and not asking hi byte with line low
    assign oe_d = !cs_n_i && (state_d == sap_pkg::SAP_IDLE)
        && !(high_byte_select_i && !rd_conv_i);

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            data_o <= sap_pkg::WORD_ZERO;
            data_oe_o <= sap_pkg::WORD_ZERO;
        end else begin
            data_o <= data_d;
            data_oe_o <= oe_d ? sap_pkg::OE_ALL : sap_pkg::WORD_ZERO;
        end
    end

    // bus handshake: one wait cycle, then waitrequest low for one edge
    assign bus_req = read_i || write_i;
    assign bus_done = bus_req && !waitrequest_o;

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            waitrequest_o <= 1'b1;
        end else if (bus_req && waitrequest_o) begin
            waitrequest_o <= 1'b0;
        end else begin
            waitrequest_o <= 1'b1;
        end
    end

    // read mux, unmapped reads as zero
    always_comb begin
        rd_mux = sap_pkg::DATA_ZERO;
        if (address_i == sap_pkg::OFS_CTRL) begin
            rd_mux[7:0] = step_div_q;
        end else if (address_i == sap_pkg::OFS_STATUS) begin
            rd_mux[2:0] = status_q;
        end else if (address_i == sap_pkg::OFS_MASK) begin
            rd_mux[2:0] = mask_q;
        end else if (address_i == sap_pkg::OFS_RESULT) begin
            rd_mux[11:0] = latch_q;
            rd_mux[sap_pkg::BUSY_BIT] = !busy_n_o;
        end
    end

    // read data captured as waitrequest drops
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            readdata_o <= sap_pkg::DATA_ZERO;
        end else if (read_i && waitrequest_o) begin
            readdata_o <= rd_mux;
        end
    end

    // register writes at the completing edge, low byte lane only
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            step_div_q <= sap_pkg::DIV_RST;
            mask_q <= sap_pkg::IRQ_NONE;
        end else if (bus_done && write_i && byteenable_i[0]) begin
            if (address_i == sap_pkg::OFS_CTRL) begin
                step_div_q <= writedata_i[7:0];
            end else if (address_i == sap_pkg::OFS_MASK) begin
                mask_q <= writedata_i[2:0];
            end
        end
    end

    // status read clears exactly the captured bits; new events win
    always_comb begin
        clr_bits = sap_pkg::IRQ_NONE;
        if (read_i && waitrequest_o && address_i == sap_pkg::OFS_STATUS) begin
            clr_bits = status_q;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            status_q <= sap_pkg::IRQ_NONE;
            irq_o <= 1'b0;
        end else begin
            status_q <= (status_q & ~clr_bits) | events;
            irq_o <= |(((status_q & ~clr_bits) | events) & mask_q);
        end
    end

    // checks on the pin behaviour
    a_top_nibble: assert property (@(posedge mclk_i) disable iff (rst_i)
        ##1 data_o.top == $past(latch_q[11:8]))
        else $error("top nibble not result bits 11..8");

    a_mid_forced_low: assert property (@(posedge mclk_i) disable iff (rst_i)
        high_byte_select_i |=> data_o.mid == sap_pkg::NIB_LOW)
        else $error("middle nibble not low in high byte mode");

    a_low_hi_byte: assert property (@(posedge mclk_i) disable iff (rst_i)
        high_byte_select_i |=> data_o.low == $past(latch_q[11:8]))
        else $error("low nibble not high byte");

    a_full_word: assert property (@(posedge mclk_i) disable iff (rst_i)
        (!high_byte_select_i && busy_n_o) |=> data_o == $past(latch_q))
        else $error("full word not presented");

    a_cs_high_z: assert property (@(posedge mclk_i) disable iff (rst_i)
        cs_n_i |=> data_oe_o == sap_pkg::WORD_ZERO)
        else $error("data driven while deselected");

    a_start_cause: assert property (@(posedge mclk_i) disable iff (rst_i)
        (state_q == sap_pkg::SAP_IDLE ##1 state_q == sap_pkg::SAP_CONV)
        |-> $past(rc_fall && !cs_n_i && !high_byte_select_i && busy_n_o))
        else $error("conversion started without valid command");

    a_busy_during: assert property (@(posedge mclk_i) disable iff (rst_i)
        start_cmd |=> !busy_n_o [*2])
        else $error("busy not low during conversion");

    a_busy_conv: assert property (@(posedge mclk_i) disable iff (rst_i)
        (state_q == sap_pkg::SAP_CONV) |-> !busy_n_o)
        else $error("busy high while converting");

    a_no_shorten: assert property (@(posedge mclk_i) disable iff (rst_i)
        (rc_fall && state_q == sap_pkg::SAP_CONV && !sar_done)
        |=> (state_q == sap_pkg::SAP_CONV && (sar_run || sar_done)))
        else $error("convert edge disturbed a conversion");

    a_start_busy: assert property (@(posedge mclk_i) disable iff (rst_i)
        start_cmd |=> (!busy_n_o && state_q == sap_pkg::SAP_CONV))
        else $error("accepted start did not begin a conversion");

    a_ignored_flag: assert property (@(posedge mclk_i) disable iff (rst_i)
        (rc_fall && state_q != sap_pkg::SAP_IDLE) |=> status_q.ignored)
        else $error("edge while busy not recorded as ignored");

    a_oe_off_busy: assert property (@(posedge mclk_i) disable iff (rst_i)
        !busy_n_o |-> data_oe_o == sap_pkg::WORD_ZERO)
        else $error("data driven before result latched");

    a_busy_after_latch: assert property (@(posedge mclk_i) disable iff (rst_i)
        $rose(busy_n_o) |-> $past(state_q) == sap_pkg::SAP_XFER
        && $past(latch_q) == $past(sar_result, 2))
        else $error("busy rose before result latched");

    a_valid_at_rise: assert property (@(posedge mclk_i) disable iff (rst_i)
        ($rose(busy_n_o) && !$past(high_byte_select_i)) |-> data_o == latch_q)
        else $error("data not valid at busy rise");

endmodule : sap_adc_ctrl

// ===== src/sap_pkg.sv
// constants, types and register map of the sampling converter control block
// assumes a single 100 MHz clock and a 32-bit Avalon-MM register slave
package sap_pkg;

    // result and pin grouping
    localparam int RES_W = 12;
    localparam int NIB_W = 4;
    localparam logic [3:0] MSB_IDX = 4'hB;
    localparam logic [11:0] MSB_MASK = 12'h800;
    localparam logic [11:0] RES_RST = 12'h000;
    localparam logic [3:0] NIB_LOW = 4'h0;

    // timing: conversion must fit in its longest time
    localparam int CLK_NS = 10;
    localparam int CONV_MAX_NS = 2700;
    localparam int CONV_MAX_CYC = CONV_MAX_NS / CLK_NS;
    localparam int STEP_MAX_CYC = CONV_MAX_CYC / RES_W;
    localparam logic [7:0] DIV_RST = 8'h13;
    localparam logic [7:0] DIV_ZERO = 8'h00;

    // register byte offsets
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_STATUS = 4'h4;
    localparam logic [3:0] OFS_MASK = 4'h8;
    localparam logic [3:0] OFS_RESULT = 4'hC;
    localparam int BUSY_BIT = 16;
    localparam logic [31:0] DATA_ZERO = 32'h0000_0000;

    // converter sequence, gray along idle, convert, transfer
    typedef enum logic [1:0] {
        SAP_IDLE = 2'b00,
        SAP_CONV = 2'b01,
        SAP_XFER = 2'b11
    } sap_state_t;

    // data pins as three nibbles, top nibble is result bits 11..8
    typedef struct packed {
        logic [3:0] top;
        logic [3:0] mid;
        logic [3:0] low;
    } sap_word_t;

    // sticky event bits, same layout in status and mask
    typedef struct packed {
        logic inhibit;
        logic ignored;
        logic done;
    } sap_irq_t;

    localparam sap_irq_t IRQ_NONE = 3'h0;
    localparam sap_word_t WORD_ZERO = 12'h000;
    localparam sap_word_t OE_ALL = 12'hFFF;

endpackage : sap_pkg

// ===== src/sap_sar_engine.sv
// successive approximation sequencer, one comparator decision per step
// assumes comp_i is high when the input is at or above the trial word
`timescale 1ns/100ps

module sap_sar_engine (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire logic [7:0] step_div_i,
    input wire logic comp_i,
    output logic [11:0] trial_o,
    output logic [11:0] result_o,
    output logic done_o,
    output logic run_o
);

    logic [7:0] cnt_q;
    logic [3:0] bit_q;
    logic [11:0] sar_d;

    // keep the tested bit per comparator, then try the next lower one
    always_comb begin
        sar_d = trial_o;
        sar_d[bit_q] = comp_i;
        if (bit_q != 4'h0) begin
            sar_d[4'(bit_q - 4'h1)] = 1'b1;
        end
    end

    // step sequencer, msb first
    always_ff @(posedge mclk_i) begin
        done_o <= 1'b0;
        if (rst_i) begin
            run_o <= 1'b0;
            cnt_q <= sap_pkg::DIV_ZERO;
            bit_q <= sap_pkg::MSB_IDX;
            trial_o <= sap_pkg::RES_RST;
            result_o <= sap_pkg::RES_RST;
        end else if (start_i && !run_o) begin
            run_o <= 1'b1;
            cnt_q <= step_div_i;
            bit_q <= sap_pkg::MSB_IDX;
            trial_o <= sap_pkg::MSB_MASK;
        end else if (run_o) begin
            if (cnt_q != sap_pkg::DIV_ZERO) begin
                cnt_q <= cnt_q - 8'h01;
            end else begin
                cnt_q <= step_div_i;
                trial_o <= sar_d;
                if (bit_q == 4'h0) begin
                    run_o <= 1'b0;
                    done_o <= 1'b1;
                    result_o <= sar_d;
                end else begin
                    bit_q <= bit_q - 4'h1;
                end
            end
        end
    end

    // a start loads the msb trial first
    a_sar_msb_first: assert property (@(posedge mclk_i) disable iff (rst_i)
        (start_i && !run_o) |=> (run_o && trial_o == sap_pkg::MSB_MASK))
        else $error("sar did not begin with msb trial");

    // the msb decision follows the comparator
    a_sar_msb_kept: assert property (@(posedge mclk_i) disable iff (rst_i)
        (run_o && cnt_q == sap_pkg::DIV_ZERO && bit_q == sap_pkg::MSB_IDX)
        |=> (trial_o[11] == $past(comp_i) && trial_o[10]))
        else $error("msb decision not taken from comparator");

endmodule : sap_sar_engine
